// ---- rtl/dwr_cfg.svh ----
// Register map, field positions and reset values of the address, reset and wake bank
`ifndef DWR_CFG_SVH
`define DWR_CFG_SVH
`define DWR_OFS_BUS_ADDR      8'h00
`define DWR_OFS_RESET_WAKE    8'h01
`define DWR_OFS_CLOCK_CFG     8'h02
`define DWR_BIT_ADDR_SRC      0
`define DWR_BIT_REMOTE_WAKE   2
`define DWR_BIT_RESTORE       1
`define DWR_BIT_LOGIC_RST     0
`define DWR_BIT_AUTO_CLOCK    5
`define DWR_RST_DEV_ADDR      7'h60
`define DWR_RST_ADDR_SRC      1'h0
`define DWR_RST_REMOTE_WAKE   1'h0
`define DWR_RST_AUTO_CLOCK    1'h0
`define DWR_BYTE_BITS         4'h8
`define DWR_BITCNT_ZERO       4'h0
`define DWR_BITCNT_ONE        4'h1
`define DWR_PTR_ONE           8'h01
`define DWR_READ_ZERO         8'h00
`endif

// ---- rtl/dwr_pkg.sv ----
// Types of the address, reset and wake bank
package dwr_pkg;
    typedef enum logic [2:0] {
        st_idle     = 3'b000,
        st_addr     = 3'b001,
        st_addr_ack = 3'b010,
        st_wdata    = 3'b011,
        st_wack     = 3'b100,
        st_rdata    = 3'b101,
        st_rack     = 3'b110
    } dwr_state_t;
endpackage

// ---- rtl/dwr_regs.sv ----
// Deserializer bus address, reset and remote wake register bank with its I2C slave
`timescale 1ns/1ps
`include "dwr_cfg.svh"
module dwr_regs (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [6:0] address_strap_pin,
    input  wire logic       pclk_valid,
    output logic            remote_wake_select,
    output logic            logic_only_reset,
    output logic            clk_out_enable,
    output logic            clk_out_osc_sel
);
    // Synchronisers
    logic               scl_m;
    logic               scl_s;
    logic               scl_d;
    logic               sda_m;
    logic               sda_s;
    logic               sda_d;
    logic               pv_m;
    logic               pv_s;
    logic [6:0]         strap_m;
    logic [6:0]         strap_s;
    // Registers
    logic [6:0]         dev_addr;
    logic               address_source_select;
    logic               auto_clock;
    logic               defaults_restore_reset;
    // Slave state
    dwr_pkg::dwr_state_t state;
    logic [3:0]         bitcnt;
    logic [7:0]         shreg;
    logic [7:0]         ptr;
    logic               ptr_phase;
    logic               rw;
    logic               nack;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_m   <= 1'h1;
            scl_s   <= 1'h1;
            scl_d   <= 1'h1;
            sda_m   <= 1'h1;
            sda_s   <= 1'h1;
            sda_d   <= 1'h1;
            pv_m    <= 1'h0;
            pv_s    <= 1'h0;
            strap_m <= 7'h00;
            strap_s <= 7'h00;
        end
        else
        begin
            scl_m   <= scl_i;
            scl_s   <= scl_m;
            scl_d   <= scl_s;
            sda_m   <= sda_i;
            sda_s   <= sda_m;
            sda_d   <= sda_s;
            pv_m    <= pclk_valid;
            pv_s    <= pv_m;
            strap_m <= address_strap_pin;
            strap_s <= strap_m;
        end
    end

    wire       scl_rise   = scl_s & ~scl_d;
    wire       scl_fall   = ~scl_s & scl_d;
    wire       bus_start  = scl_s & scl_d & sda_d & ~sda_s;
    wire       bus_stop   = scl_s & scl_d & ~sda_d & sda_s;
    wire       byte_full  = (bitcnt == `DWR_BYTE_BITS);
    wire [6:0] active_addr = address_source_select ? dev_addr : strap_s;
    wire       addr_match = (shreg[7:1] == active_addr);

    // Read decode, reserved and self-clearing bits read zero
    wire       sel_bus    = (ptr == `DWR_OFS_BUS_ADDR);
    wire       sel_rw     = (ptr == `DWR_OFS_RESET_WAKE);
    wire       sel_clk    = (ptr == `DWR_OFS_CLOCK_CFG);
    wire [7:0] rd_bus     = {dev_addr, address_source_select};
    wire [7:0] rd_rw      = {5'h00, remote_wake_select, 2'h0};
    wire [7:0] rd_clk     = {2'h0, auto_clock, 5'h00};
    wire [7:0] rd_data    = sel_bus ? rd_bus :
                            sel_rw  ? rd_rw  :
                            sel_clk ? rd_clk : `DWR_READ_ZERO;

    // Write strobe at the end of a data byte
    wire       wr_byte    = (state == dwr_pkg::st_wdata) & scl_fall & byte_full;
    wire       wr_en      = wr_byte & ptr_phase;
    wire       wr_bus     = wr_en & sel_bus;
    wire       wr_rw      = wr_en & sel_rw;
    wire       wr_clk     = wr_en & sel_clk;
    wire       next_restore = wr_rw & shreg[`DWR_BIT_RESTORE];
    wire       next_logic   = wr_rw & shreg[`DWR_BIT_LOGIC_RST];
    wire       next_clk_en  = auto_clock | pv_s;
    wire       next_clk_osc = auto_clock & ~pv_s;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dev_addr               <= `DWR_RST_DEV_ADDR;
            address_source_select  <= `DWR_RST_ADDR_SRC;
            remote_wake_select     <= `DWR_RST_REMOTE_WAKE;
            auto_clock             <= `DWR_RST_AUTO_CLOCK;
            defaults_restore_reset <= 1'h0;
            logic_only_reset       <= 1'h0;
            clk_out_enable         <= 1'h0;
            clk_out_osc_sel        <= 1'h0;
        end
        else
        begin
            defaults_restore_reset <= next_restore;
            logic_only_reset       <= next_logic;
            clk_out_enable         <= next_clk_en;
            clk_out_osc_sel        <= next_clk_osc;
            if (wr_bus)
            begin
                dev_addr              <= shreg[7:1];
                address_source_select <= shreg[`DWR_BIT_ADDR_SRC];
            end
            if (defaults_restore_reset)
            begin
                remote_wake_select <= `DWR_RST_REMOTE_WAKE;
                auto_clock         <= `DWR_RST_AUTO_CLOCK;
            end
            else
            begin
                if (wr_rw)
                    remote_wake_select <= shreg[`DWR_BIT_REMOTE_WAKE];
                if (wr_clk)
                    auto_clock <= shreg[`DWR_BIT_AUTO_CLOCK];
            end
        end
    end

    // I2C slave: sample on SCL rise, change SDA after SCL fall
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= dwr_pkg::st_idle;
            bitcnt    <= `DWR_BITCNT_ZERO;
            shreg     <= 8'h00;
            ptr       <= 8'h00;
            ptr_phase <= 1'h0;
            rw        <= 1'h0;
            nack      <= 1'h0;
            sda_o     <= 1'h0;
            sda_oe    <= 1'h0;
        end
        else if (bus_start)
        begin
            state  <= dwr_pkg::st_addr;
            bitcnt <= `DWR_BITCNT_ZERO;
            sda_oe <= 1'h0;
        end
        else if (bus_stop)
        begin
            state  <= dwr_pkg::st_idle;
            sda_oe <= 1'h0;
        end
        else
        begin
            unique case (state)
                dwr_pkg::st_idle:
                    sda_oe <= 1'h0;
                dwr_pkg::st_addr, dwr_pkg::st_wdata:
                begin
                    if (scl_rise)
                    begin
                        shreg  <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + `DWR_BITCNT_ONE;
                    end
                    else if (scl_fall && byte_full)
                    begin
                        if (state == dwr_pkg::st_addr)
                        begin
                            state     <= addr_match ? dwr_pkg::st_addr_ack : dwr_pkg::st_idle;
                            sda_oe    <= addr_match;
                            rw        <= shreg[0];
                            ptr_phase <= 1'h0;
                        end
                        else
                        begin
                            state  <= dwr_pkg::st_wack;
                            sda_oe <= 1'h1;
                            if (ptr_phase)
                                ptr <= ptr + `DWR_PTR_ONE;
                            else
                                ptr <= shreg;
                            ptr_phase <= 1'h1;
                        end
                    end
                end
                dwr_pkg::st_addr_ack, dwr_pkg::st_wack:
                begin
                    if (scl_fall)
                    begin
                        bitcnt <= `DWR_BITCNT_ZERO;
                        if (rw && state == dwr_pkg::st_addr_ack)
                        begin
                            state  <= dwr_pkg::st_rdata;
                            shreg  <= rd_data;
                            sda_oe <= ~rd_data[7];
                        end
                        else
                        begin
                            state  <= dwr_pkg::st_wdata;
                            sda_oe <= 1'h0;
                        end
                    end
                end
                dwr_pkg::st_rdata:
                begin
                    if (scl_rise)
                        bitcnt <= bitcnt + `DWR_BITCNT_ONE;
                    else if (scl_fall)
                    begin
                        if (byte_full)
                        begin
                            state  <= dwr_pkg::st_rack;
                            sda_oe <= 1'h0;
                            ptr    <= ptr + `DWR_PTR_ONE;
                        end
                        else
                        begin
                            shreg  <= {shreg[6:0], 1'h0};
                            sda_oe <= ~shreg[6];
                        end
                    end
                end
                dwr_pkg::st_rack:
                begin
                    if (scl_rise)
                        nack <= sda_s;
                    else if (scl_fall)
                    begin
                        bitcnt <= `DWR_BITCNT_ZERO;
                        if (nack)
                            state <= dwr_pkg::st_idle;
                        else
                        begin
                            state  <= dwr_pkg::st_rdata;
                            shreg  <= rd_data;
                            sda_oe <= ~rd_data[7];
                        end
                    end
                end
                default:
                    state <= dwr_pkg::st_idle;
            endcase
        end
    end
endmodule

// ---- bench/dwr_regs_monitor.sv ----
// Port checker of the address, reset and wake bank
`timescale 1ns/1ps
module dwr_regs_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic pclk_valid,
    input wire logic sda_oe,
    input wire logic remote_wake_select,
    input wire logic logic_only_reset,
    input wire logic clk_out_enable,
    input wire logic clk_out_osc_sel
);
    logic [1:0] warm;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            warm <= 2'h0;
        else if (warm != 2'h3)
            warm <= warm + 2'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    pulse_once_a: assert property (logic_only_reset |=> !logic_only_reset)
        else $error("logic reset pulse too wide");
    keep_regs_a: assert property (logic_only_reset |=> $stable(remote_wake_select) [*3])
        else $error("logic reset disturbed wake bit");
    pulse_scl_low_a: assert property (logic_only_reset |-> !scl_i)
        else $error("logic reset outside write");
    osc_enable_a: assert property (clk_out_osc_sel |-> clk_out_enable)
        else $error("oscillator selected while disabled");
    pclk_lost_a: assert property (warm == 2'h3 && !$past(pclk_valid, 3)
        |-> clk_out_enable == clk_out_osc_sel)
        else $error("clock output wrong without pixel clock");
    pclk_present_a: assert property (warm == 2'h3 && $past(pclk_valid, 3)
        |-> clk_out_enable && !clk_out_osc_sel)
        else $error("clock output wrong with pixel clock");
    wake_scl_low_a: assert property (!$stable(remote_wake_select) |-> !scl_i)
        else $error("wake bit changed outside write");
    ack_scl_low_a: assert property (!$stable(sda_oe) |-> !scl_i)
        else $error("data line changed with clock high");
endmodule
bind dwr_regs dwr_regs_monitor i_mon (.clk(clk), .rst_n(rst_n), .scl_i(scl_i),
    .pclk_valid(pclk_valid), .sda_oe(sda_oe), .remote_wake_select(remote_wake_select),
    .logic_only_reset(logic_only_reset), .clk_out_enable(clk_out_enable),
    .clk_out_osc_sel(clk_out_osc_sel));

// ---- bench/dwr_i2c_host.sv ----
// Serial bus host model facing the bank
`timescale 1ns/1ps
module dwr_i2c_host (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    logic [7:0] q;
    event       rd_ev;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic hc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start();
        sda_pull = 1'b0;
        hc(4);
        scl = 1'b1;
        hc(8);
        sda_pull = 1'b1;
        hc(8);
        scl = 1'b0;
        hc(4);
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        hc(4);
        scl = 1'b1;
        hc(8);
        sda_pull = 1'b0;
        hc(8);
    endtask
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                        output logic a);
        logic [8:0] s;
        s = {d, last};
        for (int i = 8; i >= 0; i--)
        begin
            sda_pull = !s[i];
            hc(4);
            scl = 1'b1;
            hc(4);
            s[i] = sda;
            hc(4);
            scl = 1'b0;
            hc(4);
        end
        r = s[8:1];
        a = s[0];
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic ok);
        logic [7:0] r;
        logic       n;
        start();
        xfer({a, 1'b0}, 1'b1, r, n);
        ok = !n;
        if (ok)
        begin
            xfer(p, 1'b1, r, n);
            xfer(d, 1'b1, r, n);
        end
        stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] p);
        logic n;
        start();
        xfer({a, 1'b0}, 1'b1, q, n);
        xfer(p, 1'b1, q, n);
        start();
        xfer({a, 1'b1}, 1'b1, q, n);
        xfer(8'hff, 1'b1, q, n);
        stop();
        -> rd_ev;
    endtask
endmodule

// ---- bench/tb_dwr_regs.sv ----
// Self-checking bench of the address, reset and wake bank
`timescale 1ns/1ps
module tb_dwr_regs;
    logic        clk;
    logic        rst_n;
    logic        sda;
    logic        scl;
    logic        host_pull;
    logic        sda_oe;
    logic        sda_out;
    logic [6:0]  strap;
    logic [6:0]  na;
    logic        pclk_valid;
    logic        wake;
    logic        lo_rst;
    logic        clk_en;
    logic        osc_sel;
    logic        ok;
    logic [31:0] rnd;
    logic [7:0]  exp_q[$];
    int          n_errors = 0;
    int          samples_checked = 0;
    int          seed = 7353;
    int          n_lo = 0;
    assign sda = host_pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);
    dwr_regs i_dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
        .sda_oe(sda_oe), .address_strap_pin(strap), .pclk_valid(pclk_valid),
        .remote_wake_select(wake), .logic_only_reset(lo_rst), .clk_out_enable(clk_en),
        .clk_out_osc_sel(osc_sel));
    dwr_i2c_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(host_pull));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = !clk;
    end
    always @(posedge clk)
        if (lo_rst === 1'b1)
            n_lo++;
    task automatic chk(input logic [7:0] g, e);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rde(input logic [6:0] a, input logic [7:0] p, e);
        exp_q.push_back(e);
        i_host.rd(a, p);
    endtask
    task automatic clks(input logic auto);
        for (int i = 0; i < 6; i++)
        begin
            rnd = $random(seed);
            pclk_valid = (i < 2) ? i[0] : rnd[0];
            repeat (5) @(negedge clk);
            chk({6'h00, clk_en, osc_sel}, {6'h00, auto | pclk_valid, auto & !pclk_valid});
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
        forever
        begin
            @(i_host.rd_ev);
            chk(i_host.q, exp_q.pop_front());
        end
    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        results();
    end
    initial
    begin
        rst_n = 1'b0;
        pclk_valid = 1'b0;
        rnd = $random(seed);
        strap = rnd[6:0];
        na = strap ^ 7'h2a;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        rde(strap, 8'h00, 8'hc0);
        rde(strap, 8'h05, 8'h00);
        i_host.wr(strap, 8'h00, {na, 1'b1}, ok);
        chk({7'h00, ok}, 8'h01);
        i_host.wr(strap, 8'h01, 8'h04, ok);
        chk({7'h00, ok}, 8'h00);
        rde(na, 8'h00, {na, 1'b1});
        i_host.wr(na, 8'h01, 8'h04, ok);
        chk({7'h00, wake}, 8'h01);
        rde(na, 8'h01, 8'h04);
        i_host.wr(na, 8'h01, 8'hf9, ok);
        chk({wake, n_lo[6:0]}, 8'h01);
        rde(na, 8'h01, 8'h00);
        i_host.wr(na, 8'h01, 8'h04, ok);
        i_host.wr(na, 8'h02, 8'hff, ok);
        rde(na, 8'h02, 8'h20);
        clks(1'b1);
        i_host.wr(na, 8'h01, 8'h06, ok);
        chk({wake, n_lo[6:0]}, 8'h01);
        rde(na, 8'h02, 8'h00);
        rde(na, 8'h00, {na, 1'b1});
        clks(1'b0);
        results();
    end
endmodule
